// File: rtl/csrb_core_special_register_bank.sv
// Core special register group: indirect port, timer0 window, program counter, status, pointer, first port
`timescale 1ns/10ps
module csrb_core_special_register_bank (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire csrb_pkg::csrb_access_t        access,
  output      logic                          rd_valid,
  output      logic [csrb_pkg::DATA_W-1:0]   rd_data,
  output      csrb_pkg::csrb_mem_req_t       mem_req,
  input  wire logic [csrb_pkg::DATA_W-1:0]   mem_rdata,
  input  wire csrb_pkg::csrb_pc_cmd_t        pc_cmd,
  output      logic [csrb_pkg::PC_W-1:0]     pc,
  output      logic                          stack_push,
  output      logic [csrb_pkg::PC_W-1:0]     stack_push_addr,
  input  wire csrb_pkg::csrb_alu_flags_t     alu_flags,
  input  wire logic                          sleep_exec,
  input  wire logic                          watchdog_clear,
  input  wire logic                          watchdog_timeout,
  output      logic [csrb_pkg::DATA_W-1:0]   core_status_flags,
  output      logic [csrb_pkg::DATA_W-1:0]   file_select_pointer,
  input  wire logic                          instruction_clock_rate,
  input  wire logic                          timer0_mode_select,
  input  wire logic                          timer0_ext_source_cfg,
  input  wire logic                          timer0_ext_clock_pin,
  input  wire logic                          low_osc_clock_pin,
  output      logic [csrb_pkg::DATA_W-1:0]   timer0_count,
  output      logic                          timer0_overflow,
  input  wire logic [csrb_pkg::DATA_W-1:0]   first_port_pins,
  input  wire logic [csrb_pkg::DATA_W-1:0]   first_port_dir_input,
  input  wire logic                          port_read_source_option,
  output      logic [csrb_pkg::DATA_W-1:0]   first_port_latch
);
  import csrb_pkg::*;

  // True for a location in the special register window
  function automatic logic is_sfr(input logic [LOC_W-1:0] loc);
    return loc < LOC_SFR_LIMIT;
  endfunction

  // Next sequential program address
  function automatic logic [PC_W-1:0] pc_next(input logic [PC_W-1:0] cur);
    return cur + PC_STEP;
  endfunction

  logic [1:0]        pc_high_buffer;
  logic [LOC_W-1:0]  eff_loc;
  logic [BANK_W-1:0] eff_bank;
  logic              wr_sfr;
  logic              s1_valid;
  logic              s1_sfr;
  logic [LOC_W-1:0]  s1_loc;
  logic [DATA_W-1:0] port_read;
  logic [1:0]        clk_sync1;
  logic [1:0]        clk_sync2;
  logic [1:0]        clk_prev;
  logic              timer_tick;
  logic [DATA_W-1:0] port_sync1;
  logic [DATA_W-1:0] port_sync2;

  // Resolve the addressed location; the indirect port redirects through the pointer
  always_comb begin
    if (access.loc == LOC_INDIRECT) begin
      eff_loc = file_select_pointer[FS_LOC_HI:0];
    end else begin
      eff_loc = access.loc;
    end
    eff_bank = file_select_pointer[FS_BANK_HI:FS_BANK_LO];
    wr_sfr   = access.valid && access.write && is_sfr(eff_loc);
  end

  // Stage one: remember what a read asked for, forward memory traffic
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_valid <= 1'b0;
      s1_sfr   <= 1'b0;
      s1_loc   <= LOC_INDIRECT;
      mem_req  <= '0;
    end else begin
      s1_valid      <= access.valid && !access.write;
      s1_sfr        <= is_sfr(eff_loc);
      s1_loc        <= eff_loc;
      // Special locations never leave the block, whatever the bank
      mem_req.valid <= access.valid && !is_sfr(eff_loc);
      mem_req.write <= access.write;
      mem_req.bank  <= eff_bank;
      mem_req.loc   <= eff_loc;
      mem_req.wdata <= access.wdata;
    end
  end

  // First port read source per bit
  always_comb begin
    for (int i = 0; i < DATA_W; i++) begin
      if (first_port_dir_input[i] || !port_read_source_option) begin
        port_read[i] = port_sync2[i];
      end else begin
        port_read[i] = first_port_latch[i];
      end
    end
  end

  // Stage two: read answer; values are sampled now so the timer is live
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rd_valid <= 1'b0;
      rd_data  <= READ_ZERO;
    end else begin
      rd_valid <= s1_valid;
      if (!s1_sfr) begin
        rd_data <= mem_rdata;
      end else begin
        unique case (s1_loc)
          LOC_TIMER0:      rd_data <= timer0_count;
          LOC_PC_LOW:      rd_data <= pc[DATA_W-1:0];
          LOC_STATUS:      rd_data <= core_status_flags;
          LOC_FILE_SELECT: rd_data <= file_select_pointer;
          LOC_FIRST_PORT:  rd_data <= port_read;
          LOC_PC_HIGH_BUF: rd_data <= {6'h00, pc_high_buffer};
          // Indirect-to-indirect and the other special slots read as zero
          default:         rd_data <= READ_ZERO;
        endcase
      end
    end
  end

  // Pin inputs pass two flip-flops before anything looks at them
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      port_sync1 <= RST_PORT_LATCH;
      port_sync2 <= RST_PORT_LATCH;
      clk_sync1  <= 2'h0;
      clk_sync2  <= 2'h0;
      clk_prev   <= 2'h0;
    end else begin
      port_sync1 <= first_port_pins;
      port_sync2 <= port_sync1;
      // Bit 1 low oscillator pin, bit 0 external timer pin
      clk_sync1  <= {low_osc_clock_pin, timer0_ext_clock_pin};
      clk_sync2  <= clk_sync1;
      clk_prev   <= clk_sync2;
    end
  end

  // Timer0 source: instruction clock, or a rising edge of the chosen slow pin
  always_comb begin
    if (!timer0_mode_select) begin
      timer_tick = instruction_clock_rate;
    end else if (timer0_ext_source_cfg) begin
      timer_tick = clk_sync2[1] && !clk_prev[1];
    end else begin
      timer_tick = clk_sync2[0] && !clk_prev[0];
    end
  end

  // Timer0 count; a software write beats a tick in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timer0_count    <= RST_TIMER0;
      timer0_overflow <= 1'b0;
    end else begin
      timer0_overflow <= 1'b0;
      if (wr_sfr && eff_loc == LOC_TIMER0) begin
        timer0_count <= access.wdata;
      end else if (timer_tick) begin
        timer0_count    <= timer0_count + TIMER_STEP;
        timer0_overflow <= timer0_count == TIMER_MAX;
      end
    end
  end

  // High buffer feeds the upper counter bits on low-byte writes and short calls, bit 9 only on short jumps; long jumps and calls use the target
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_high_buffer <= RST_PC_HIGH;
    end else if (wr_sfr && eff_loc == LOC_PC_HIGH_BUF) begin
      pc_high_buffer <= access.wdata[1:0];
    end
  end

  // Program counter; a low-byte write is itself the retiring instruction, so it wins
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc              <= RST_PC;
      stack_push      <= 1'b0;
      stack_push_addr <= RST_PC;
    end else begin
      stack_push <= 1'b0;
      if (wr_sfr && eff_loc == LOC_PC_LOW) begin
        pc <= {pc_high_buffer, access.wdata};
      end else if (pc_cmd.valid) begin
        unique case (pc_cmd.op)
          CSRB_PC_SEQUENTIAL: pc <= pc_next(pc);
          CSRB_PC_SHORT_JUMP: pc <= {pc_high_buffer[1], pc_cmd.target[8:0]};
          CSRB_PC_SHORT_CALL: begin
            pc              <= {pc_high_buffer, pc_cmd.target[7:0]};
            stack_push      <= 1'b1;
            stack_push_addr <= pc_next(pc);
          end
          CSRB_PC_LONG_JUMP:  pc <= pc_cmd.target;
          CSRB_PC_LONG_CALL: begin
            pc              <= pc_cmd.target;
            stack_push      <= 1'b1;
            stack_push_addr <= pc_next(pc);
          end
          // Illegal op codes leave the counter alone
          default:            pc <= pc;
        endcase
      end
    end
  end

  // Status: software write first, then hardware events override their fields
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_status_flags <= RST_STATUS;
    end else begin
      if (wr_sfr && eff_loc == LOC_STATUS) begin
        core_status_flags <= access.wdata;
      end
      if (alu_flags.valid) begin
        core_status_flags[ST_CARRY]      <= alu_flags.carry;
        core_status_flags[ST_HALF_CARRY] <= alu_flags.half_carry;
        core_status_flags[ST_ZERO]       <= alu_flags.zero;
      end
      // The watchdog clear sets both flags and beats sleep or timeout in the same cycle
      if (watchdog_clear) begin
        core_status_flags[ST_POWER_DOWN] <= 1'b1;
        core_status_flags[ST_TIMEOUT]    <= 1'b1;
      end else if (sleep_exec) begin
        core_status_flags[ST_POWER_DOWN] <= 1'b0;
        core_status_flags[ST_TIMEOUT]    <= 1'b1;
      end else if (watchdog_timeout) begin
        core_status_flags[ST_TIMEOUT]    <= 1'b0;
      end
    end
  end

  // Pointer and first port latch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      file_select_pointer <= RST_FILE_SELECT;
      first_port_latch    <= RST_PORT_LATCH;
    end else begin
      if (wr_sfr && eff_loc == LOC_FILE_SELECT) begin
        file_select_pointer <= access.wdata;
      end
      if (wr_sfr && eff_loc == LOC_FIRST_PORT) begin
        first_port_latch <= access.wdata;
      end
    end
  end

  // Checks on the logic above
  a_indirect_redirect: assert property (@(posedge clk) disable iff (!reset_n)
    access.valid && access.loc == LOC_INDIRECT && !is_sfr(file_select_pointer[FS_LOC_HI:0])
    |=> mem_req.valid && mem_req.loc == $past(file_select_pointer[FS_LOC_HI:0]))
    else $error("indirect access not redirected through pointer");
  a_sfr_alias_local: assert property (@(posedge clk) disable iff (!reset_n)
    access.valid && is_sfr(eff_loc) |=> !mem_req.valid)
    else $error("special location leaked to memory");
  a_timer_live_read: assert property (@(posedge clk) disable iff (!reset_n)
    s1_valid && s1_sfr && s1_loc == LOC_TIMER0 |=> rd_valid && rd_data == $past(timer0_count))
    else $error("timer read not live");
  a_timer_write_now: assert property (@(posedge clk) disable iff (!reset_n)
    wr_sfr && eff_loc == LOC_TIMER0 |=> timer0_count == $past(access.wdata))
    else $error("timer write not applied");
  a_pc_step_one: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.valid && pc_cmd.op == CSRB_PC_SEQUENTIAL && !wr_sfr |=> pc == $past(pc) + PC_STEP)
    else $error("counter did not advance by one");
  a_short_jump_load: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.valid && pc_cmd.op == CSRB_PC_SHORT_JUMP && !wr_sfr
    |=> pc == {$past(pc_high_buffer[1]), $past(pc_cmd.target[8:0])})
    else $error("short jump target wrong");
  a_short_call_push: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.valid && pc_cmd.op == CSRB_PC_SHORT_CALL && !wr_sfr
    |=> stack_push && stack_push_addr == $past(pc) + PC_STEP
        && pc == {$past(pc_high_buffer), $past(pc_cmd.target[7:0])})
    else $error("short call wrong");
  a_long_jump_load: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.valid && pc_cmd.op == CSRB_PC_LONG_JUMP && !wr_sfr |=> pc == $past(pc_cmd.target) && !stack_push)
    else $error("long jump wrong");
  a_long_call_push: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.valid && pc_cmd.op == CSRB_PC_LONG_CALL && !wr_sfr
    |=> stack_push && pc == $past(pc_cmd.target) && stack_push_addr == $past(pc) + PC_STEP)
    else $error("long call wrong");
  a_alu_flag_copy: assert property (@(posedge clk) disable iff (!reset_n)
    alu_flags.valid |=> core_status_flags[ST_CARRY] == $past(alu_flags.carry)
      && core_status_flags[ST_HALF_CARRY] == $past(alu_flags.half_carry)
      && core_status_flags[ST_ZERO] == $past(alu_flags.zero))
    else $error("arithmetic flags not updated");
  a_sleep_flags: assert property (@(posedge clk) disable iff (!reset_n)
    sleep_exec && !watchdog_clear |=> !core_status_flags[ST_POWER_DOWN] && core_status_flags[ST_TIMEOUT])
    else $error("sleep flags wrong");
  a_timeout_clear: assert property (@(posedge clk) disable iff (!reset_n)
    watchdog_timeout && !watchdog_clear && !sleep_exec |=> !core_status_flags[ST_TIMEOUT])
    else $error("timeout flag not cleared");
  a_pc_low_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_sfr && eff_loc == LOC_PC_LOW |=> pc == {$past(pc_high_buffer), $past(access.wdata)})
    else $error("computed jump wrong");
  a_port_latch_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_sfr && eff_loc == LOC_FIRST_PORT |=> first_port_latch == $past(access.wdata))
    else $error("port latch not written");

  // Checks on forwarding, counter holding, status fields and read paths
  a_bank_forward: assert property (@(posedge clk) disable iff (!reset_n)
    access.valid && !is_sfr(eff_loc)
    |=> mem_req.valid && mem_req.write == $past(access.write) && mem_req.wdata == $past(access.wdata)
        && mem_req.bank == $past(file_select_pointer[FS_BANK_HI:FS_BANK_LO]))
    else $error("memory request fields wrong");
  a_direct_location: assert property (@(posedge clk) disable iff (!reset_n)
    access.valid && access.loc != LOC_INDIRECT && !is_sfr(access.loc) |=> mem_req.loc == $past(access.loc))
    else $error("direct location not taken from the opcode field");
  a_pointer_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_sfr && eff_loc == LOC_FILE_SELECT |=> file_select_pointer == $past(access.wdata))
    else $error("pointer not written");
  a_buffer_low_bits: assert property (@(posedge clk) disable iff (!reset_n)
    wr_sfr && eff_loc == LOC_PC_HIGH_BUF |=> pc_high_buffer == $past(access.wdata[1:0]))
    else $error("high buffer not written");
  a_pc_hold_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !pc_cmd.valid && !(wr_sfr && eff_loc == LOC_PC_LOW) |=> pc == $past(pc))
    else $error("counter moved without an instruction");
  a_jump_no_push: assert property (@(posedge clk) disable iff (!reset_n)
    pc_cmd.valid && (pc_cmd.op == CSRB_PC_SEQUENTIAL || pc_cmd.op == CSRB_PC_SHORT_JUMP
      || pc_cmd.op == CSRB_PC_LONG_JUMP) |=> !stack_push)
    else $error("stack push without a call");
  a_spare_bits_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !(wr_sfr && eff_loc == LOC_STATUS)
    |=> core_status_flags[ST_SPARE_HI:ST_SPARE_LO] == $past(core_status_flags[ST_SPARE_HI:ST_SPARE_LO]))
    else $error("spare status bits changed by hardware");
  a_clear_sets_flags: assert property (@(posedge clk) disable iff (!reset_n)
    watchdog_clear |=> core_status_flags[ST_POWER_DOWN] && core_status_flags[ST_TIMEOUT])
    else $error("watchdog clear did not set reset-cause flags");
  a_port_pin_read: assert property (@(posedge clk) disable iff (!reset_n)
    s1_valid && s1_sfr && s1_loc == LOC_FIRST_PORT && !port_read_source_option
    |=> rd_data == $past(port_sync2))
    else $error("port read did not return pin levels");
  a_timer_tick_step: assert property (@(posedge clk) disable iff (!reset_n)
    timer_tick && !(wr_sfr && eff_loc == LOC_TIMER0) |=> timer0_count == $past(timer0_count) + TIMER_STEP)
    else $error("timer did not count a tick");
  a_timer_hold_idle: assert property (@(posedge clk) disable iff (!reset_n)
    !timer_tick && !(wr_sfr && eff_loc == LOC_TIMER0) |=> $stable(timer0_count))
    else $error("timer moved without a tick");
  a_timer_wrap_flag: assert property (@(posedge clk) disable iff (!reset_n)
    timer_tick && !(wr_sfr && eff_loc == LOC_TIMER0) && timer0_count == TIMER_MAX |=> timer0_overflow)
    else $error("timer wrap not flagged");
  a_read_latency: assert property (@(posedge clk) disable iff (!reset_n)
    access.valid && !access.write |-> ##2 rd_valid)
    else $error("read answer not two cycles later");
  a_memory_read_back: assert property (@(posedge clk) disable iff (!reset_n)
    s1_valid && !s1_sfr |=> rd_data == $past(mem_rdata))
    else $error("memory read data not returned");
  a_pc_low_read: assert property (@(posedge clk) disable iff (!reset_n)
    s1_valid && s1_sfr && s1_loc == LOC_PC_LOW |=> rd_data == $past(pc[DATA_W-1:0]))
    else $error("low byte read wrong");

endmodule

// File: rtl/csrb_pkg.sv
// Shared constants and carrier types for the core special register bank
package csrb_pkg;

  // Location and field widths
  localparam int LOC_W  = 6;
  localparam int BANK_W = 2;
  localparam int PC_W   = 10;
  localparam int DATA_W = 8;

  // Special register locations, present in every bank
  localparam logic [LOC_W-1:0] LOC_INDIRECT    = 6'h00;
  localparam logic [LOC_W-1:0] LOC_TIMER0      = 6'h01;
  localparam logic [LOC_W-1:0] LOC_PC_LOW      = 6'h02;
  localparam logic [LOC_W-1:0] LOC_STATUS      = 6'h03;
  localparam logic [LOC_W-1:0] LOC_FILE_SELECT = 6'h04;
  localparam logic [LOC_W-1:0] LOC_FIRST_PORT  = 6'h05;
  localparam logic [LOC_W-1:0] LOC_PC_HIGH_BUF = 6'h0A;
  localparam logic [LOC_W-1:0] LOC_SFR_LIMIT   = 6'h10;

  // Status field positions
  localparam int ST_CARRY      = 0;
  localparam int ST_HALF_CARRY = 1;
  localparam int ST_ZERO       = 2;
  localparam int ST_POWER_DOWN = 3;
  localparam int ST_TIMEOUT    = 4;
  localparam int ST_SPARE_LO   = 5;
  localparam int ST_SPARE_HI   = 7;

  // File select pointer fields
  localparam int FS_BANK_HI = 7;
  localparam int FS_BANK_LO = 6;
  localparam int FS_LOC_HI  = 5;

  // Reset values and other fixed constants
  localparam logic [DATA_W-1:0] RST_STATUS      = 8'h18;
  localparam logic [DATA_W-1:0] RST_FILE_SELECT = 8'h00;
  localparam logic [PC_W-1:0]   RST_PC          = 10'h000;
  localparam logic [1:0]        RST_PC_HIGH     = 2'h0;
  localparam logic [DATA_W-1:0] RST_TIMER0      = 8'h00;
  localparam logic [DATA_W-1:0] RST_PORT_LATCH  = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO       = 8'h00;
  localparam logic [BANK_W-1:0] BANK_ZERO       = 2'h0;
  localparam logic [PC_W-1:0]   PC_STEP         = 10'h001;
  localparam logic [DATA_W-1:0] TIMER_STEP      = 8'h01;
  localparam logic [DATA_W-1:0] TIMER_MAX       = 8'hFF;

  // Program counter operations reported by the instruction sequencer
  typedef enum logic [2:0] {
    CSRB_PC_SEQUENTIAL,
    CSRB_PC_SHORT_JUMP,
    CSRB_PC_SHORT_CALL,
    CSRB_PC_LONG_JUMP,
    CSRB_PC_LONG_CALL
  } csrb_pc_op_t;

  // Data-memory access from an instruction
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [LOC_W-1:0]  loc;
    logic [DATA_W-1:0] wdata;
  } csrb_access_t;

  // Retired instruction with its program counter effect
  typedef struct packed {
    logic            valid;
    csrb_pc_op_t     op;
    logic [PC_W-1:0] target;
  } csrb_pc_cmd_t;

  // Arithmetic flag update
  typedef struct packed {
    logic valid;
    logic carry;
    logic half_carry;
    logic zero;
  } csrb_alu_flags_t;

  // Forwarded general purpose memory access
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [BANK_W-1:0] bank;
    logic [LOC_W-1:0]  loc;
    logic [DATA_W-1:0] wdata;
  } csrb_mem_req_t;

endpackage

// File: testbench/csrb_core_special_register_bank_test.sv
// Self-checking bench for the core special register bank
`timescale 1ns/10ps
module csrb_core_special_register_bank_test;
  import csrb_pkg::*;
  logic            clk = 0, reset_n = 0, rd_valid, push, ovf;
  logic            slp = 0, wclr = 0, wto = 0, tick = 0, tmode = 0, tcfg = 0, extp = 0, losc = 0, ropt = 0;
  csrb_access_t    acc = '0;
  csrb_pc_cmd_t    pcc = '0;
  csrb_alu_flags_t alu = '0;
  csrb_mem_req_t   mreq;
  csrb_mem_req_t   mq[$];
  logic [7:0]      rd_data, stat, fsp, tcnt, latch, v, w, mrd = 0, pins = 0, dirin = 0;
  logic [7:0]      rq[$];
  logic [9:0]      pc, paddr;
  int              n_fail = 0, checks = 0, cyc = 0;

  always #10 clk = ~clk;

  csrb_core_special_register_bank u_dut (
    .clk(clk), .reset_n(reset_n), .access(acc), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_req(mreq), .mem_rdata(mrd), .pc_cmd(pcc), .pc(pc), .stack_push(push),
    .stack_push_addr(paddr), .alu_flags(alu), .sleep_exec(slp), .watchdog_clear(wclr),
    .watchdog_timeout(wto), .core_status_flags(stat), .file_select_pointer(fsp),
    .instruction_clock_rate(tick), .timer0_mode_select(tmode), .timer0_ext_source_cfg(tcfg),
    .timer0_ext_clock_pin(extp), .low_osc_clock_pin(losc), .timer0_count(tcnt),
    .timer0_overflow(ovf), .first_port_pins(pins), .first_port_dir_input(dirin),
    .port_read_source_option(ropt), .first_port_latch(latch)
  );

  task automatic check(input string nm, input logic [17:0] got, input logic [17:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One register access; returns at the edge that takes it
  task automatic acc_op(input logic wr, input logic [5:0] loc, input logic [7:0] d);
    @(posedge clk);
    acc <= {1'b1, wr, loc, d};
    @(posedge clk);
    acc <= '0;
  endtask

  // Read with its expected answer noted for the monitor
  task automatic rd(input logic [5:0] loc, input logic [7:0] e);
    rq.push_back(e);
    acc_op(1'b0, loc, 8'h00);
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pc_chk(input csrb_pc_op_t op, input logic [9:0] t, input logic [9:0] epc,
                        input logic epush, input logic [9:0] eaddr);
    @(posedge clk);
    pcc <= {1'b1, op, t};
    @(posedge clk);
    pcc <= '0;
    @(negedge clk);
    check("pc", pc, epc);
    check("stack_push", push, epush);
    if (epush)
      check("stack_push_addr", paddr, eaddr);
  endtask

  // Three timer ticks from source k: 0 instruction clock, 1 ext pin, 2 low osc pin
  task automatic ticks(input int k);
    repeat (3) begin
      @(posedge clk);
      if (k == 0) tick <= 1'b1;
      else if (k == 1) extp <= 1'b1;
      else losc <= 1'b1;
      repeat (k == 0 ? 1 : 4) @(posedge clk);
      tick <= 1'b0;
      extp <= 1'b0;
      losc <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask

  task automatic ev(input logic s, input logic c, input logic t, input logic [1:0] e);
    @(posedge clk);
    slp <= s;
    wclr <= c;
    wto <= t;
    @(posedge clk);
    {slp, wclr, wto} <= 3'h0;
    @(negedge clk);
    check("status_reset_cause", stat[4:3], e);
  endtask

  // Answers are paired with the oldest note; also cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (reset_n && rd_valid === 1'b1) begin
      if (rq.size() > 0)
        check("rd_data", rd_data, rq.pop_front());
      else
        check("rd_unexpected", 1'b1, 1'b0);
    end
    if (reset_n && mreq.valid === 1'b1) begin
      if (mq.size() > 0)
        check("mem_req", mreq, mq.pop_front());
      else
        check("mem_req_unexpected", 1'b1, 1'b0);
    end
    if (cyc > 6000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(42490));
    mrd <= 8'($urandom);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("status", stat, RST_STATUS);
    check("pointer", fsp, 8'h00);
    check("pc", pc, 10'h000);
    rd(LOC_PC_LOW, 8'h00);
    w = 8'($urandom);
    acc_op(1'b1, LOC_FILE_SELECT, w);
    @(negedge clk);
    check("pointer", fsp, w);
    rd(LOC_FILE_SELECT, w);
    // Every bank: indirect read, direct write, special alias
    for (int b = 0; b < 4; b++) begin
      acc_op(1'b1, LOC_FILE_SELECT, {b[1:0], 6'h25});
      mq.push_back({1'b1, 1'b0, b[1:0], 6'h25, 8'h00});
      rd(LOC_INDIRECT, mrd);
      w = 8'($urandom);
      mq.push_back({1'b1, 1'b1, b[1:0], 6'h30, w});
      acc_op(1'b1, 6'h30, w);
      rd(LOC_STATUS, RST_STATUS);
    end
    acc_op(1'b1, LOC_FILE_SELECT, 8'h00);
    rd(LOC_INDIRECT, 8'h00);
    // Timer from each clock source
    for (int k = 0; k < 3; k++) begin
      v = 8'($urandom);
      acc_op(1'b1, LOC_TIMER0, v);
      rd(LOC_TIMER0, v);
      tmode <= (k != 0);
      tcfg <= (k == 2);
      ticks(k);
      gap(6);
      // Count wraps at eight bits, so the sum is cut before comparing
      w = v + 8'h03;
      @(negedge clk);
      check("timer0_count", tcnt, w);
      rd(LOC_TIMER0, w);
      gap(3);
    end
    // Program counter loads; buffer holds only bits 1:0
    acc_op(1'b1, LOC_PC_HIGH_BUF, 8'hFE);
    rd(LOC_PC_HIGH_BUF, 8'h02);
    pc_chk(CSRB_PC_SEQUENTIAL, 10'h3FF, 10'h001, 1'b0, 10'h000);
    pc_chk(CSRB_PC_SHORT_JUMP, 10'h0AB, 10'h2AB, 1'b0, 10'h000);
    pc_chk(CSRB_PC_SHORT_CALL, 10'h1CD, 10'h2CD, 1'b1, 10'h2AC);
    pc_chk(CSRB_PC_LONG_JUMP, 10'h155, 10'h155, 1'b0, 10'h000);
    pc_chk(CSRB_PC_LONG_CALL, 10'h3F0, 10'h3F0, 1'b1, 10'h156);
    pc_chk(CSRB_PC_SEQUENTIAL, 10'h000, 10'h3F1, 1'b0, 10'h000);
    acc_op(1'b1, LOC_PC_LOW, 8'h40);
    @(negedge clk);
    check("pc", pc, 10'h240);
    rd(LOC_PC_LOW, 8'h40);
    // Arithmetic flags, all combinations
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      alu <= {1'b1, i[2:0]};
      @(posedge clk);
      alu <= '0;
      @(negedge clk);
      check("status", stat, {5'b00011, i[0], i[1], i[2]});
    end
    ev(1'b1, 1'b0, 1'b0, 2'b10);
    ev(1'b0, 1'b0, 1'b1, 2'b00);
    ev(1'b0, 1'b1, 1'b0, 2'b11);
    ev(1'b0, 1'b1, 1'b1, 2'b11);
    acc_op(1'b1, LOC_STATUS, 8'hE5);
    rd(LOC_STATUS, 8'hE5);
    // First port: latch write, then both read sources
    w = 8'($urandom);
    pins <= 8'h3C;
    dirin <= 8'h0F;
    acc_op(1'b1, LOC_FIRST_PORT, w);
    @(negedge clk);
    check("port_latch", latch, w);
    gap(3);
    rd(LOC_FIRST_PORT, 8'h3C);
    gap(4);
    ropt <= 1'b1;
    gap(3);
    rd(LOC_FIRST_PORT, (8'h3C & 8'h0F) | (w & 8'hF0));
    gap(6);
    // Timer wrap from the instruction clock raises a one-cycle overflow pulse
    tmode <= 1'b0;
    acc_op(1'b1, LOC_TIMER0, TIMER_MAX);
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    @(negedge clk);
    check("timer0_overflow", ovf, 1'b1);
    check("timer0_count", tcnt, RST_TIMER0);
    @(negedge clk);
    check("timer0_overflow", ovf, 1'b0);
    // Reset in mid-run brings counter, pointer, status, port latch and timer0 back to their reset values
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("pc", pc, RST_PC);
    check("pointer", fsp, RST_FILE_SELECT);
    check("status", stat, RST_STATUS);
    check("port_latch", latch, RST_PORT_LATCH);
    check("timer0_count", tcnt, RST_TIMER0);
    rd(LOC_PC_LOW, 8'h00);
    gap(6);
    check("reads_left", rq.size(), 0);
    check("mem_req_left", mq.size(), 0);
    give_verdict();
  end
endmodule
